// ### hdl/sscd_core.sv
// module: spi command interpreter, argument collector and response builder
//
// The address map and the address-and-strobe port are this design's own decisions.
`timescale 1ns/1ns
module sscd_core
  import sscd_pkg::*;
#(
  parameter logic [2*NREGS-1:0] REG_LEN_TABLE = REG_LEN_DEFAULT,
  parameter logic [NREGS-1:0]   REG_RO_MASK   = REG_RO_DEFAULT,
  parameter logic [NREGS-1:0]   REG_COND_MASK = REG_CND_DEFAULT
) (
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              spi_sck,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_mosi,
  output logic                   spi_miso,
  input  wire logic              motor_running,
  input  wire logic              motion_busy,
  input  wire logic [STAT_W-1:0] status_in,
  output logic [SEL_W-1:0]       reg_rd_addr,
  input  wire logic [ARG_W-1:0]  reg_rd_data,
  output logic                   reg_wr_en,
  output logic [SEL_W-1:0]       reg_wr_addr,
  output logic [ARG_W-1:0]       reg_wr_data,
  output logic                   cmd_valid,
  output sscd_cmd_e              cmd_kind,
  output logic                   cmd_dir,
  output logic                   cmd_act,
  output logic [ARG_W-1:0]       cmd_arg,
  output logic                   device_reset,
  output logic                   unknown_cmd_flag,
  output logic                   command_rejected_flag
);

  typedef enum logic {ST_OPCODE, ST_ARGS} sscd_state_e;

  ////////////////////////////////////////////////////////////////////////////
  // helpers

  function automatic logic [CNT_W-1:0] reg_len(input logic [SEL_W-1:0] sel);
    return REG_LEN_TABLE[CNT_W*sel +: CNT_W];
  endfunction : reg_len

  // left-align a 1..3 byte value so the msb byte goes first
  function automatic logic [ARG_W-1:0] align_msb(input logic [ARG_W-1:0] v,
                                                 input logic [CNT_W-1:0] n);
    logic [ARG_W-1:0] r;
    r = v;
    if (n == LEN_ONE) r = {v[BYTE_W-1:0], {(ARG_W-BYTE_W){1'b0}}};
    else if (n == LEN_TWO) r = {v[2*BYTE_W-1:0], {BYTE_W{1'b0}}};
    return r;
  endfunction : align_msb

  ////////////////////////////////////////////////////////////////////////////
  // spi byte link

  logic              rx_valid;
  logic [BYTE_W-1:0] rx_byte;
  logic [BYTE_W-1:0] tx_reg;

  sscd_spi_byte u_spi (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .spi_sck  (spi_sck),
    .spi_cs_n (spi_cs_n),
    .spi_mosi (spi_mosi),
    .spi_miso (spi_miso),
    .tx_byte  (tx_reg),
    .rx_valid (rx_valid),
    .rx_byte  (rx_byte)
  );

  ////////////////////////////////////////////////////////////////////////////
  // state

  logic             devrst_reg;
  logic             core_rst;
  sscd_state_e      state_reg, state_next;
  logic [CNT_W-1:0] cnt_reg, cnt_next;
  sscd_cmd_e        kind_reg, kind_next;
  logic [7:0]       op_reg, op_next;
  logic [ARG_W-1:0] arg_reg, arg_next;
  logic             unk_reg;
  logic             rej_reg;
  logic [ARG_W-1:0] resp_reg;
  logic [CNT_W-1:0] resp_left_reg;

  // a decoded reset command restarts everything but the byte link
  assign core_rst = sys_rst | devrst_reg; // R16

  ////////////////////////////////////////////////////////////////////////////
  // decode of the byte just received

  sscd_cmd_e        rx_kind;
  logic [SEL_W-1:0] rx_sel;
  logic [CNT_W-1:0] rx_len;
  logic             rx_ro;
  logic [STAT_W-1:0] status_word;

  assign rx_kind     = sscd_decode(rx_byte); // R05
  assign rx_sel      = rx_byte[SEL_W-1:0];
  assign rx_len      = reg_len(rx_sel);
  assign rx_ro       = REG_RO_MASK[rx_sel];
  assign reg_rd_addr = rx_sel;

  always_comb begin
    status_word               = status_in;
    status_word[UNK_FLAG_BIT] = unk_reg;
    status_word[REJ_FLAG_BIT] = rej_reg;
  end

  ////////////////////////////////////////////////////////////////////////////
  // command sequencing

  logic             fire;
  logic             unk_set;
  logic             flag_clr;
  logic             load_resp;
  logic [ARG_W-1:0] resp_val;
  logic [CNT_W-1:0] resp_len;

  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    kind_next  = kind_reg;
    op_next    = op_reg;
    arg_next   = arg_reg;
    fire       = 1'b0;
    unk_set    = 1'b0;
    flag_clr   = 1'b0;
    load_resp  = 1'b0;
    resp_val   = '0;
    resp_len   = LEN_NONE;
    if (rx_valid) begin
      unique case (state_reg)
        ST_OPCODE: begin
          op_next   = rx_byte; // R01
          kind_next = rx_kind;
          arg_next  = '0;
          unique case (rx_kind)
            CMD_NOP: begin
              fire = 1'b0; // R25
            end
            CMD_BAD: begin
              unk_set = 1'b1; // R05 R26
            end
            CMD_WRITE: begin
              if (rx_len == LEN_NONE || rx_ro) begin
                unk_set = 1'b1; // R21
              end else begin
                state_next = ST_ARGS; // R06
                cnt_next   = rx_len; // R20
              end
            end
            CMD_READ: begin
              if (rx_len == LEN_NONE) begin
                unk_set = 1'b1; // R24
              end else begin
                load_resp = 1'b1; // R07
                resp_val  = reg_rd_data;
                resp_len  = rx_len; // R03
              end
            end
            CMD_STATUS: begin
              load_resp = 1'b1; // R19
              resp_val  = {{(ARG_W-STAT_W){1'b0}}, status_word};
              resp_len  = STATUS_LEN;
              flag_clr  = 1'b1; // R23
            end
            CMD_RUN, CMD_MOVE, CMD_GO_TO_POSITION_COMMAND, CMD_DIRECTED_POSITION_COMMAND, CMD_UNTIL: begin
              state_next = ST_ARGS; // R01
              cnt_next   = MOTION_ARGS;
            end
            default: begin
              fire = 1'b1;
            end
          endcase
        end
        ST_ARGS: begin
          arg_next = {arg_reg[ARG_W-BYTE_W-1:0], rx_byte}; // R20
          cnt_next = cnt_reg - LEN_ONE;
          if (cnt_reg == LEN_ONE) begin
            state_next = ST_OPCODE;
            fire       = 1'b1;
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refusal checks at the end of the last byte

  logic is_write;
  logic refuse;
  logic accept;

  assign is_write = kind_next == CMD_WRITE;
  always_comb begin
    refuse = 1'b0;
    if ((kind_next == CMD_MOVE || kind_next == CMD_STEPCLK) && motor_running)
      refuse = 1'b1; // R10
    if ((kind_next == CMD_GO_TO_POSITION_COMMAND || kind_next == CMD_DIRECTED_POSITION_COMMAND) && motion_busy)
      refuse = 1'b1; // R11
    if (is_write && REG_COND_MASK[op_next[SEL_W-1:0]] && motor_running)
      refuse = 1'b1; // R22
  end
  assign accept = fire & ~refuse;

  always_ff @(posedge clk) begin
    if (core_rst) begin
      state_reg <= ST_OPCODE;
      cnt_reg   <= LEN_NONE;
      kind_reg  <= CMD_NOP;
      op_reg    <= OPC_NOP;
      arg_reg   <= '0;
    end else begin
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      kind_reg  <= kind_next;
      op_reg    <= op_next;
      arg_reg   <= arg_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latched flags: a set in the clearing cycle survives

  always_ff @(posedge clk) begin
    if (core_rst) begin
      unk_reg <= 1'b0;
      rej_reg <= 1'b0;
    end else begin
      unk_reg <= (unk_reg & ~flag_clr) | unk_set; // R23
      rej_reg <= (rej_reg & ~flag_clr) | (fire & refuse); // R22
    end
  end

  assign unknown_cmd_flag      = unk_reg;
  assign command_rejected_flag = rej_reg;

  ////////////////////////////////////////////////////////////////////////////
  // response buffer: every received byte advances it by one, except a status opcode or a read of a present register, which reloads it

  logic [ARG_W-1:0] resp_aligned;
  assign resp_aligned = align_msb(resp_val, resp_len);

  always_ff @(posedge clk) begin
    if (core_rst) begin
      tx_reg        <= '0;
      resp_reg      <= '0;
      resp_left_reg <= LEN_NONE;
    end else if (load_resp) begin
      tx_reg        <= resp_aligned[ARG_W-1 -: BYTE_W]; // R04
      resp_reg      <= {resp_aligned[ARG_W-BYTE_W-1:0], {BYTE_W{1'b0}}};
      resp_left_reg <= resp_len - LEN_ONE; // R03
    end else if (rx_valid) begin
      if (resp_left_reg != LEN_NONE) begin
        tx_reg        <= resp_reg[ARG_W-1 -: BYTE_W];
        resp_reg      <= {resp_reg[ARG_W-BYTE_W-1:0], {BYTE_W{1'b0}}};
        resp_left_reg <= resp_left_reg - LEN_ONE;
      end else begin
        tx_reg <= '0; // R02
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // dispatch to the motion engine and register file

  always_ff @(posedge clk) begin
    if (core_rst) begin
      reg_wr_en <= 1'b0;
      cmd_valid <= 1'b0;
    end else begin
      reg_wr_en <= accept & is_write; // R06
      cmd_valid <= accept & ~is_write; // R08 R09 R12 R13 R14 R15 R17 R18
    end
  end

  // payload held between pulses; dir and act come from the opcode byte
  always_ff @(posedge clk) begin
    if (core_rst) begin
      reg_wr_addr <= '0;
      reg_wr_data <= '0;
      cmd_kind    <= CMD_NOP;
      cmd_dir     <= 1'b0;
      cmd_act     <= 1'b0;
      cmd_arg     <= '0;
    end else if (accept) begin
      reg_wr_addr <= op_next[SEL_W-1:0];
      reg_wr_data <= arg_next;
      cmd_kind    <= kind_next;
      cmd_dir     <= op_next[DIR_BIT]; // R08 R11
      cmd_act     <= op_next[ACT_BIT]; // R12 R13
      cmd_arg     <= arg_next;
    end
  end

  // reset pulse must not clear itself through the core reset
  always_ff @(posedge clk) begin
    if (sys_rst) devrst_reg <= 1'b0;
    else devrst_reg <= accept & (kind_next == CMD_DEVRST); // R16
  end

  assign device_reset = devrst_reg;

endmodule : sscd_core

// ### hdl/sscd_pkg.sv
// package: opcode patterns, masks, field positions and counts for the spi command decoder
// Function
// R01: one opcode byte, then zero to three arguments
// R02: zero response byte for every ordinary byte
// R03: reads answer with one to three bytes
// R04: new reading command replaces running response
// R05: unknown opcode ignored, unknown flag set
// R06: group 000 writes selected register
// R07: group 001 returns selected register value
// R08: run sets speed and direction
// R09: step clock mode with direction, no arguments
// R10: move by steps, refused while running
// R11: go to position, shortest or forced direction
// R12: run until switch closes, then decelerate
// R13: back off switch slowly, then stop hard
// R14: return home or to marker
// R15: clear absolute position to zero
// R16: device reset restores power-up state
// R17: decelerating stop and immediate stop
// R18: decelerating float and immediate float
// R19: status read returns status word
// R20: write value sent msb first, exact length
// R21: write to missing/read-only register: unknown flag
// R22: conditional write refused: rejected flag at end
// R23: flags hold until status read
// R24: read of missing register: unknown flag
// R25: all-zero byte is no operation
// R26: reserved 111 opcodes count as unknown
package sscd_pkg;

  localparam int BYTE_W = 8;
  localparam int SEL_W  = 5;
  localparam int ARG_W  = 24;
  localparam int CNT_W  = 2;
  localparam int STAT_W = 16;
  localparam int NREGS  = 32;

  localparam logic [7:0] GRP_MASK     = 8'he0;
  localparam logic [7:0] GRP_WRITE    = 8'h00;
  localparam logic [7:0] GRP_READ     = 8'h20;
  localparam logic [7:0] DIR_MASK     = 8'hfe;
  localparam logic [7:0] ACT_DIR_MASK = 8'hf6;

  localparam logic [7:0] OPC_NOP      = 8'h00;
  localparam logic [7:0] OPC_RUN      = 8'h50;
  localparam logic [7:0] OPC_STEPCLK  = 8'h58;
  localparam logic [7:0] OPC_MOVE     = 8'h40;
  localparam logic [7:0] OPC_GO_TO_POSITION_COMMAND     = 8'h60;
  localparam logic [7:0] OPC_DIRECTED_POSITION_COMMAND = 8'h68;
  localparam logic [7:0] OPC_UNTIL    = 8'h82;
  localparam logic [7:0] OPC_RELEASE  = 8'h92;
  localparam logic [7:0] OPC_HOME     = 8'h70;
  localparam logic [7:0] OPC_MARK     = 8'h78;
  localparam logic [7:0] OPC_CLRPOS   = 8'hd8;
  localparam logic [7:0] OPC_DEVRST   = 8'hc0;
  localparam logic [7:0] OPC_SSTOP    = 8'hb0;
  localparam logic [7:0] OPC_HSTOP    = 8'hb8;
  localparam logic [7:0] OPC_SHIZ     = 8'ha0;
  localparam logic [7:0] OPC_HHIZ     = 8'ha8;
  localparam logic [7:0] OPC_STATUS   = 8'hd0;

  localparam int DIR_BIT      = 0;
  localparam int ACT_BIT      = 3;
  localparam int UNK_FLAG_BIT = 8;
  localparam int REJ_FLAG_BIT = 7;

  localparam logic [CNT_W-1:0] LEN_NONE    = 2'h0;
  localparam logic [CNT_W-1:0] LEN_ONE     = 2'h1;
  localparam logic [CNT_W-1:0] LEN_TWO     = 2'h2;
  localparam logic [CNT_W-1:0] STATUS_LEN  = 2'h2;
  localparam logic [CNT_W-1:0] MOTION_ARGS = 2'h3;

  localparam logic [2*NREGS-1:0] REG_LEN_DEFAULT = {{(NREGS-1){2'h3}}, 2'h0};
  localparam logic [NREGS-1:0]   REG_RO_DEFAULT  = 32'h0000_0000;
  localparam logic [NREGS-1:0]   REG_CND_DEFAULT = 32'h0000_0000;

  typedef enum logic [4:0] {
    CMD_NOP, CMD_WRITE, CMD_READ, CMD_RUN, CMD_STEPCLK, CMD_MOVE, CMD_GO_TO_POSITION_COMMAND,
    CMD_DIRECTED_POSITION_COMMAND, CMD_UNTIL, CMD_RELEASE, CMD_HOME, CMD_MARK, CMD_CLRPOS,
    CMD_DEVRST, CMD_SSTOP, CMD_HSTOP, CMD_SHIZ, CMD_HHIZ, CMD_STATUS, CMD_BAD
  } sscd_cmd_e;

  function automatic sscd_cmd_e sscd_decode(input logic [7:0] b);
    sscd_cmd_e k;
    k = CMD_BAD;
    if (b == OPC_NOP) k = CMD_NOP;
    else if ((b & GRP_MASK) == GRP_WRITE) k = CMD_WRITE;
    else if ((b & GRP_MASK) == GRP_READ) k = CMD_READ;
    else if ((b & DIR_MASK) == OPC_RUN) k = CMD_RUN;
    else if ((b & DIR_MASK) == OPC_STEPCLK) k = CMD_STEPCLK;
    else if ((b & DIR_MASK) == OPC_MOVE) k = CMD_MOVE;
    else if (b == OPC_GO_TO_POSITION_COMMAND) k = CMD_GO_TO_POSITION_COMMAND;
    else if ((b & DIR_MASK) == OPC_DIRECTED_POSITION_COMMAND) k = CMD_DIRECTED_POSITION_COMMAND;
    else if ((b & ACT_DIR_MASK) == OPC_UNTIL) k = CMD_UNTIL;
    else if ((b & ACT_DIR_MASK) == OPC_RELEASE) k = CMD_RELEASE;
    else if (b == OPC_HOME) k = CMD_HOME;
    else if (b == OPC_MARK) k = CMD_MARK;
    else if (b == OPC_CLRPOS) k = CMD_CLRPOS;
    else if (b == OPC_DEVRST) k = CMD_DEVRST;
    else if (b == OPC_SSTOP) k = CMD_SSTOP;
    else if (b == OPC_HSTOP) k = CMD_HSTOP;
    else if (b == OPC_SHIZ) k = CMD_SHIZ;
    else if (b == OPC_HHIZ) k = CMD_HHIZ;
    else if (b == OPC_STATUS) k = CMD_STATUS;
    return k;
  endfunction : sscd_decode

endpackage : sscd_pkg

// ### hdl/sscd_spi_byte.sv
// module: spi slave byte shifter, sck sampled by the system clock
`timescale 1ns/1ns
module sscd_spi_byte
  import sscd_pkg::*;
(
  input  wire logic              clk,
  input  wire logic              sys_rst,
  input  wire logic              spi_sck,
  input  wire logic              spi_cs_n,
  input  wire logic              spi_mosi,
  output logic                   spi_miso,
  input  wire logic [BYTE_W-1:0] tx_byte,
  output logic                   rx_valid,
  output logic [BYTE_W-1:0]      rx_byte
);

  ////////////////////////////////////////////////////////////////////////////
  // two-stage synchronisers, then one more stage for edge detection
  logic [2:0] sck_sync_reg;
  logic [2:0] cs_sync_reg;
  logic [1:0] mosi_sync_reg;

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      sck_sync_reg  <= '1;
      cs_sync_reg   <= '1;
      mosi_sync_reg <= 2'h0;
    end else begin
      sck_sync_reg  <= {sck_sync_reg[1:0], spi_sck};
      cs_sync_reg   <= {cs_sync_reg[1:0], spi_cs_n};
      mosi_sync_reg <= {mosi_sync_reg[0], spi_mosi};
    end
  end

  wire sck_rise = sck_sync_reg[1] & ~sck_sync_reg[2];
  wire sck_fall = ~sck_sync_reg[1] & sck_sync_reg[2];
  wire selected = ~cs_sync_reg[1];
  wire cs_fall  = selected & cs_sync_reg[2];

  ////////////////////////////////////////////////////////////////////////////
  // mode 3: sample on rising, shift out on falling; frame is one byte
  logic [BYTE_W-1:0] rx_sr_reg;
  logic [BYTE_W-1:0] tx_sr_reg;
  logic [2:0]        bit_cnt_reg;
  logic              byte_end;

  assign byte_end = selected & sck_rise & (bit_cnt_reg == 3'(BYTE_W - 1));

  always_ff @(posedge clk) begin
    if (sys_rst || !selected) begin
      bit_cnt_reg <= 3'h0;
      rx_sr_reg   <= '0;
    end else if (sck_rise) begin
      bit_cnt_reg <= bit_cnt_reg + 3'h1;
      rx_sr_reg   <= {rx_sr_reg[BYTE_W-2:0], mosi_sync_reg[1]};
    end
  end

  // tx byte latched at select so a late decoder update cannot tear a byte
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_sr_reg <= '0;
      spi_miso  <= 1'b0;
    end else if (cs_fall) begin
      tx_sr_reg <= tx_byte;
    end else if (selected && sck_fall) begin
      spi_miso  <= tx_sr_reg[BYTE_W-1];
      tx_sr_reg <= {tx_sr_reg[BYTE_W-2:0], 1'b0};
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_valid <= 1'b0;
      rx_byte  <= '0;
    end else begin
      rx_valid <= byte_end;
      if (byte_end) rx_byte <= {rx_sr_reg[BYTE_W-2:0], mosi_sync_reg[1]};
    end
  end

endmodule : sscd_spi_byte

// ### verification/sscd_core_props.sv
// checker: port-level timing and legality properties of the command decoder
`timescale 1ns/1ns
module sscd_core_props
  import sscd_pkg::*;
#(
  parameter logic [2*NREGS-1:0] REG_LEN_TABLE = REG_LEN_DEFAULT,
  parameter logic [NREGS-1:0]   REG_RO_MASK   = REG_RO_DEFAULT,
  parameter logic [NREGS-1:0]   REG_COND_MASK = REG_CND_DEFAULT
) (
  input wire logic             clk,
  input wire logic             sys_rst,
  input wire logic             spi_cs_n,
  input wire logic             motor_running,
  input wire logic             motion_busy,
  input wire logic             reg_wr_en,
  input wire logic [SEL_W-1:0] reg_wr_addr,
  input wire sscd_cmd_e        cmd_kind,
  input wire logic             cmd_valid,
  input wire logic             device_reset,
  input wire logic             unknown_cmd_flag,
  input wire logic             command_rejected_flag
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);

  wire logic [CNT_W-1:0] wr_len;
  assign wr_len = REG_LEN_TABLE[2*reg_wr_addr +: 2];

  ////////////////////////////////////////////////////////////////////////
  // eight cycles is shorter than any byte frame, longer than decode delay
  sequence s_link_idle;
    spi_cs_n [*8];
  endsequence
  sequence s_running;
    motor_running [*8];
  endsequence
  sequence s_busy;
    motion_busy [*8];
  endsequence

  ////////////////////////////////////////////////////////////////////////
  a_pulse_single: assert property (cmd_valid |=> !cmd_valid && !reg_wr_en)
    else $error("dispatch pulse not single");
  a_quiet_idle: assert property (s_link_idle |-> !cmd_valid && !reg_wr_en && !device_reset)
    else $error("action without a received byte");
  a_flags_steady: assert property (s_link_idle |=> $stable(unknown_cmd_flag) && $stable(command_rejected_flag))
    else $error("flag moved with link idle");
  a_move_refused: assert property (s_running ##1 cmd_valid |-> !(cmd_kind inside {CMD_MOVE, CMD_STEPCLK}))
    else $error("move dispatched while running");
  a_go_to_position_command_refused: assert property (s_busy ##1 cmd_valid |-> !(cmd_kind inside {CMD_GO_TO_POSITION_COMMAND, CMD_DIRECTED_POSITION_COMMAND}))
    else $error("go-to dispatched while busy");
  a_write_legal: assert property (reg_wr_en |-> wr_len != LEN_NONE && !REG_RO_MASK[reg_wr_addr])
    else $error("write to missing or read-only register");
  a_write_cond: assert property (s_running ##1 reg_wr_en |-> !REG_COND_MASK[reg_wr_addr])
    else $error("conditional write while running");
  a_reject_cause: assert property ($rose(command_rejected_flag) |-> motor_running || motion_busy)
    else $error("rejected flag without cause");
  a_unknown_inert: assert property ($rose(unknown_cmd_flag) |-> !cmd_valid && !reg_wr_en)
    else $error("unknown byte caused an action");
  a_reset_clears: assert property (device_reset |-> ##2 !unknown_cmd_flag && !command_rejected_flag)
    else $error("flags survive device reset");
endmodule : sscd_core_props

bind sscd_core sscd_core_props #(
  .REG_LEN_TABLE(REG_LEN_TABLE), .REG_RO_MASK(REG_RO_MASK), .REG_COND_MASK(REG_COND_MASK)
) sscd_core_props_i (
  .clk(clk), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n), .motor_running(motor_running), .motion_busy(motion_busy),
  .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr), .cmd_kind(cmd_kind), .cmd_valid(cmd_valid),
  .device_reset(device_reset), .unknown_cmd_flag(unknown_cmd_flag), .command_rejected_flag(command_rejected_flag)
);

// ### verification/sscd_host_model.sv
// partner: behavioural spi host, mode 3, one byte per select frame
`timescale 1ns/1ns
module sscd_host_model (
  output logic      spi_sck,
  output logic      spi_cs_n,
  output logic      spi_mosi,
  input  wire logic spi_miso
);
  initial begin
    spi_sck = 1'b1;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b1;
  end

  ////////////////////////////////////////////////////////////////////////
  // sck stands high outside frames; select held well past the 8th rise
  task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
    spi_cs_n = 1'b0;
    #83;
    for (int i = 7; i >= 0; i--) begin
      spi_sck = 1'b0;
      spi_mosi = tx[i];
      #62;
      spi_sck = 1'b1;
      rx[i] = spi_miso;
      #63;
    end
    #40;
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi; // released line shows no stale bit
    #97;
  endtask : xfer
endmodule : sscd_host_model

// ### verification/tb_top.sv
// testbench: spi command traffic with expected dispatch, flags and responses
`timescale 1ns/1ns
module tb_top
  import sscd_pkg::*;
;
  localparam logic [2*NREGS-1:0] TB_LEN = (REG_LEN_DEFAULT & ~(64'h3 << 18) & ~(64'h3 << 8)) | (64'h1 << 8);
  localparam logic [15:0]        ST     = 16'hc37e;
  logic              clk, sys_rst, motor_running, motion_busy, reg_wr_en, cmd_valid, cmd_dir, cmd_act;
  logic              device_reset, unknown_cmd_flag, command_rejected_flag;
  logic [STAT_W-1:0] status_in;
  logic [SEL_W-1:0]  reg_rd_addr, reg_wr_addr;
  logic [ARG_W-1:0]  reg_rd_data, reg_wr_data, cmd_arg;
  wire logic         spi_sck, spi_cs_n, spi_mosi, spi_miso;
  sscd_cmd_e         cmd_kind;
  int                err_total, num_checks, n_cmd, n_wr, n_rst, c0, na;
  logic [7:0]        rx_b;
  logic [15:0]       st_b;
  logic [7:0]        dops [14] = '{8'h51, 8'h59, 8'h40, 8'h60, 8'h69, 8'h8b, 8'h92, 8'h70, 8'h78, 8'hd8, 8'hb0,
                                   8'hb8, 8'ha0, 8'ha8};
  sscd_cmd_e         dkind [14] = '{CMD_RUN, CMD_STEPCLK, CMD_MOVE, CMD_GO_TO_POSITION_COMMAND, CMD_DIRECTED_POSITION_COMMAND, CMD_UNTIL, CMD_RELEASE,
                                    CMD_HOME, CMD_MARK, CMD_CLRPOS, CMD_SSTOP, CMD_HSTOP, CMD_SHIZ, CMD_HHIZ};
  logic [7:0]        uops [7] = '{8'h09, 8'h07, 8'h29, 8'h44, 8'heb, 8'hf8, 8'hff};
  logic [7:0]        rops [4] = '{8'h41, 8'h58, 8'h60, 8'h69};

  // register file stand-in: value carries its own selector
  assign reg_rd_data = {3'h0, reg_rd_addr, 8'ha5, 3'h0, reg_rd_addr};

  sscd_core #(.REG_LEN_TABLE(TB_LEN), .REG_RO_MASK(32'h0000_0080), .REG_COND_MASK(32'h0000_0040)) sscd_core_i (
    .clk(clk), .sys_rst(sys_rst), .spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi),
    .spi_miso(spi_miso), .motor_running(motor_running), .motion_busy(motion_busy), .status_in(status_in),
    .reg_rd_addr(reg_rd_addr), .reg_rd_data(reg_rd_data), .reg_wr_en(reg_wr_en), .reg_wr_addr(reg_wr_addr),
    .reg_wr_data(reg_wr_data), .cmd_valid(cmd_valid), .cmd_kind(cmd_kind), .cmd_dir(cmd_dir),
    .cmd_act(cmd_act), .cmd_arg(cmd_arg), .device_reset(device_reset), .unknown_cmd_flag(unknown_cmd_flag),
    .command_rejected_flag(command_rejected_flag)
  );
  sscd_host_model sscd_host_model_i (.spi_sck(spi_sck), .spi_cs_n(spi_cs_n), .spi_mosi(spi_mosi), .spi_miso(spi_miso));

  ////////////////////////////////////////////////////////////////////////
  always #5 clk = ~clk;

  always @(posedge clk) begin
    if (cmd_valid === 1'b1) n_cmd++;
    if (reg_wr_en === 1'b1) n_wr++;
    if (device_reset === 1'b1) n_rst++;
  end

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  task automatic send(input logic [7:0] b);
    sscd_host_model_i.xfer(b, rx_b);
  endtask : send

  // only for bytes whose answer must be all zero
  task automatic cmd(input logic [7:0] op, input int n, input logic [23:0] arg);
    send(op);
    chk("response", 24'h0, 24'(rx_b));
    for (int k = n - 1; k >= 0; k--) begin
      send(arg[8*k +: 8]);
      chk("response", 24'h0, 24'(rx_b));
    end
  endtask : cmd

  task automatic flags(input logic u, input logic r);
    chk("unknown flag", 24'(u), 24'(unknown_cmd_flag));
    chk("rejected flag", 24'(r), 24'(command_rejected_flag));
  endtask : flags

  task automatic status(input logic u, input logic r);
    send(OPC_STATUS);
    send(8'h00);
    st_b[15:8] = rx_b;
    send(8'h00);
    st_b[7:0] = rx_b;
    chk("status word", 24'({ST[15:9], u, r, ST[6:0]}), 24'(st_b));
  endtask : status

  task automatic hold(input logic r, input logic b);
    @(posedge clk);
    motor_running <= r;
    motion_busy <= b;
    repeat (2) @(posedge clk);
  endtask : hold

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : print_verdict

  initial begin
    repeat (100000) @(posedge clk);
    err_total++;
    print_verdict();
  end

  ////////////////////////////////////////////////////////////////////////
  initial begin
    clk = 1'b0;
    sys_rst = 1'b1;
    motor_running = 1'b0;
    motion_busy = 1'b0;
    status_in = ST;
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    repeat (4) @(posedge clk);
    flags(1'b0, 1'b0);
    chk("idle kind", 24'(CMD_NOP), 24'(cmd_kind));
    foreach (dops[i]) begin
      na = (dkind[i] inside {CMD_RUN, CMD_MOVE, CMD_GO_TO_POSITION_COMMAND, CMD_DIRECTED_POSITION_COMMAND, CMD_UNTIL}) ? 3 : 0;
      c0 = n_cmd;
      cmd(dops[i], na, 24'h0abcde);
      chk("dispatch count", 24'(c0 + 1), 24'(n_cmd));
      chk("command kind", 24'(dkind[i]), 24'(cmd_kind));
      chk("direction", 24'(dops[i][0]), 24'(cmd_dir));
      if (dkind[i] inside {CMD_UNTIL, CMD_RELEASE}) chk("action", 24'(dops[i][3]), 24'(cmd_act));
      if (na == 3) chk("argument", 24'h0abcde, cmd_arg);
    end
    c0 = n_wr;
    cmd(8'h00, 0, 24'h0);
    flags(1'b0, 1'b0);
    cmd(8'h05, 3, 24'h123456);
    chk("write select", 24'h5, 24'(reg_wr_addr));
    chk("write value", 24'h123456, reg_wr_data);
    cmd(8'h04, 1, 24'h0000c7);
    cmd(8'h00, 0, 24'h0);
    chk("short write", 24'h0000c7, reg_wr_data);
    chk("write count", 24'(c0 + 2), 24'(n_wr));
    send(8'h25);
    send(8'h00);
    chk("read byte", 24'h05, 24'(rx_b));
    send(8'h00);
    chk("read byte", 24'ha5, 24'(rx_b));
    send(8'h00);
    chk("read byte", 24'h05, 24'(rx_b));
    send(8'h00);
    chk("read tail", 24'h00, 24'(rx_b));
    send(8'h24);
    send(8'h00);
    chk("short read", 24'h04, 24'(rx_b));
    send(8'h00);
    chk("short tail", 24'h00, 24'(rx_b));
    send(8'h25);
    send(OPC_STATUS);
    chk("read before swap", 24'h05, 24'(rx_b));
    send(8'h00);
    chk("swapped status", 24'({ST[15:9], 1'b0}), 24'(rx_b));
    send(8'h00);
    chk("swapped status", 24'({1'b0, ST[6:0]}), 24'(rx_b));
    foreach (uops[i]) begin
      c0 = n_cmd + n_wr;
      send(uops[i]);
      flags(1'b1, 1'b0);
      chk("ignored byte", 24'(c0), 24'(n_cmd + n_wr));
      status(1'b1, 1'b0);
      flags(1'b0, 1'b0);
    end
    hold(1'b1, 1'b0);
    c0 = n_wr;
    send(8'h06);
    send(8'h11);
    send(8'h22);
    flags(1'b0, 1'b0);
    send(8'h33);
    flags(1'b0, 1'b1);
    cmd(8'h05, 3, 24'h00beef);
    chk("write count", 24'(c0 + 1), 24'(n_wr));
    status(1'b0, 1'b1);
    hold(1'b1, 1'b1);
    c0 = n_cmd;
    cmd(8'h51, 3, 24'h000200);
    chk("dispatch count", 24'(c0 + 1), 24'(n_cmd));
    foreach (rops[i]) begin
      hold(i < 2, i >= 2);
      c0 = n_cmd;
      cmd(rops[i], (i == 1) ? 0 : 3, 24'h000010);
      chk("refused dispatch", 24'(c0), 24'(n_cmd));
      status(1'b0, 1'b1);
    end
    hold(1'b0, 1'b0);
    send(8'hff);
    c0 = n_rst;
    cmd(OPC_DEVRST, 0, 24'h0);
    chk("device reset", 24'(c0 + 1), 24'(n_rst));
    flags(1'b0, 1'b0);
    print_verdict();
  end
endmodule : tb_top
